// [reset_ctrl_regs.svh]
// register map, reset values, field positions and timing constants of the reset controller
// Functional notes
// R1 - seven reset causes: power-on, clear pin, clear wake, watchdog, watchdog wake, pin wake, brown-out
// R2 - unaffected registers are unknown at power-on and keep contents otherwise
// R3 - any wake from halt gives a full reset, never a resumption
// R4 - cause flags in status bits 7, 4, 3; power-on loads 1001 1xxx
// R5 - power-on, clear and watchdog resets load defined register reset states
// R6 - program counter low byte loads all ones on every cause
// R7 - clear-pin reset in run clears status bits 6 and 5 only
// R8 - clear-pin reset in run keeps the time-out and power-down flags
// R9 - watchdog reset in run loads status u000 1uuu
// R10 - watchdog-clear instruction sets time-out and power-down flags
// R11 - pin wake clears status bits 7..5; brown-out gives x00x xxxx
// R12 - direction all ones, option 3Fh; extension 3Fh at power-on, kept otherwise; the code clears the extension to 00h on brown-out
// R13 - file registers 07-1Fh kept on warm resets; pointer top three bits set
// R14 - core held in reset for startup hold time: 18 ms, or 1 ms RC warm
// R15 - startup hold timer restarted by every reset cause
// R16 - simultaneous causes: power-on wins, then brown-out, then the others
// R17 - reset requests synchronised; internal reset released on a clock edge
`ifndef RESET_CTRL_REGS_SVH
`define RESET_CTRL_REGS_SVH

// register indices, not apb byte addresses (printed offsets are not word multiples: byte address is index times four)
`define IDX_INDIRECT_DATA_PORT 5'h00
`define IDX_TIMER_COUNT        5'h01
`define IDX_PROGRAM_COUNTER_LOW 5'h02
`define IDX_STATUS_FLAGS       5'h03
`define IDX_INDIRECT_POINTER   5'h04
`define IDX_PORT_A_LATCH       5'h05
`define IDX_PORT_B_LATCH       5'h06
`define IDX_GPR_FIRST          5'h07
`define IDX_GPR_LAST           5'h1F
`define IDX_WORKING_ACC        6'h20
`define IDX_PIN_DIRECTION      6'h21
`define IDX_TIMER_OPTION       6'h22
`define IDX_OPTION_EXT         6'h23
`define IDX_CAUSE_CTRL         6'h24
`define IDX_HOLD_STATUS        6'h25

// status field positions
`define ST_PIN_WAKE_N  7
`define ST_PAGE_HI     6
`define ST_PAGE_LO     5
`define ST_TIMEOUT_N   4
`define ST_POWERDOWN_N 3

// reset values
`define RST_ALL_ONES   8'hFF
`define RST_OPTION     6'h3F
`define RST_PTR_TOP    3'h7
`define RST_STATUS_POR 8'h98

// startup hold times in microseconds and clock rate in kHz
`define HOLD_LONG_US   18000
`define HOLD_SHORT_US  1000
`define CLOCK_KHZ      10000
`define HOLD_LONG_CYC  ((`HOLD_LONG_US * `CLOCK_KHZ) / 1000)
`define HOLD_SHORT_CYC ((`HOLD_SHORT_US * `CLOCK_KHZ) / 1000)

`endif

// [reset_ctrl_pkg.sv]
// types shared by the reset controller modules
package reset_ctrl_pkg;
  typedef enum logic [7:0] {
    CAUSE_NONE      = 8'h00,
    CAUSE_POR       = 8'h01,
    CAUSE_CLR_RUN   = 8'h02,
    CAUSE_CLR_WAKE  = 8'h04,
    CAUSE_WDT_RUN   = 8'h08,
    CAUSE_WDT_WAKE  = 8'h10,
    CAUSE_PIN_WAKE  = 8'h20,
    CAUSE_BROWNOUT  = 8'h40
  } cause_t;

  typedef enum logic [2:0] {
    HOLD_IDLE = 3'b001,
    HOLD_WAIT = 3'b010,
    HOLD_RUN  = 3'b100
  } hold_state_t;
endpackage

// [hold_if.sv]
// carries the start request and the hold indication between controller and hold timer
interface hold_if;
  logic        start;
  logic        short_sel;
  logic        busy;
  modport ctrl  (output start, output short_sel, input busy);
  modport timer (input start, input short_sel, output busy);
endinterface

// [startup_hold_timer.sv]
// startup hold timer: keeps the core in reset for the long or short period
`include "reset_ctrl_regs.svh"
module startup_hold_timer
  import reset_ctrl_pkg::*;
#(
  parameter int unsigned LONG_CYC  = `HOLD_LONG_CYC,
  parameter int unsigned SHORT_CYC = `HOLD_SHORT_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  hold_if.timer    hif
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  hold_state_t st_q;
  hold_state_t st_d;

  // a new start reloads at any time, so a cause during the hold restarts it
  always_comb begin
    cnt_d = cnt_q;
    st_d  = st_q;
    case (st_q)
      HOLD_IDLE: begin
        if (hif.start) begin
          st_d = HOLD_RUN;
        end
      end
      HOLD_RUN: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= (hif.short_sel ? SHORT_CYC : LONG_CYC) - 32'h1) begin
          st_d = HOLD_IDLE;
        end
      end
      default: st_d = HOLD_IDLE;
    endcase
    if (hif.start) begin // R15
      cnt_d = 32'h0;
      st_d  = HOLD_RUN;
    end
  end

  // power-up begins in the running hold
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 32'h0;
      st_q  <= HOLD_RUN;
    end else begin
      cnt_q <= cnt_d;
      st_q  <= st_d;
    end
  end

  assign hif.busy = (st_q != HOLD_IDLE); // R14

  AST_HOLD_END: assert property (@(posedge clock) disable iff (!nrst)
    (st_q == HOLD_RUN && !hif.start && hif.short_sel && cnt_q == SHORT_CYC - 32'h1)
      |=> st_q == HOLD_IDLE) // R14
    else $error("hold timer did not end at its period");
  AST_HOLD_RESTART: assert property (@(posedge clock) disable iff (!nrst)
    hif.start |=> (cnt_q == 32'h0 && st_q == HOLD_RUN)) // R15
    else $error("start did not restart hold timer");
endmodule

// [reset_source_state_control.sv]
// reset source capture, status flag update and core register reset states behind apb
//
// Chosen here: the APB register port.
`include "reset_ctrl_regs.svh"
module reset_source_state_control
  import reset_ctrl_pkg::*;
#(
  parameter int unsigned LONG_CYC  = `HOLD_LONG_CYC,
  parameter int unsigned SHORT_CYC = `HOLD_SHORT_CYC
) (
  // clock and power-on reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset sources, asynchronous
  input  wire logic        master_clear_pin_n,
  input  wire logic        watchdog_timeout,
  input  wire logic        pin_change,
  input  wire logic        brownout,
  // core side, same clock
  input  wire logic        halted,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        rc_osc_mode,
  output logic             core_reset,
  output logic [7:0]       last_cause
);
  //////////////////////////////////////////////////////////////////////////////
  // synchronisers: first stage only feeds the second
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q  <= 4'h0;
    end else begin
      sync1_q <= {brownout, pin_change, watchdog_timeout, ~master_clear_pin_n}; // R17
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // rising edges of the synchronised requests; pin change counts only while halted
  logic clr_ev;
  logic wdt_ev;
  logic pin_ev;
  logic bod_ev;
  assign clr_ev = sync2_q[0] & ~prev_q[0];
  assign wdt_ev = sync2_q[1] & ~prev_q[1];
  assign pin_ev = sync2_q[2] & ~prev_q[2] & halted;

  //////////////////////////////////////////////////////////////////////////////
  // register file state
  logic [7:0] status_q, status_d;
  logic [7:0] pcl_q, pcl_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] tmr_q, tmr_d;
  logic [3:0] port_a_latch_q, port_a_latch_d;
  logic [7:0] port_b_latch_q, port_b_latch_d;
  logic [7:0] wacc_q, wacc_d;
  logic [7:0] dir_q, dir_d;
  logic [5:0] opt_q, opt_d;
  logic [5:0] optx_q, optx_d;
  logic [7:0] gpr_q [25];
  logic [7:0] gpr_d [25];
  logic       bod_enable_q, bod_enable_d;
  logic       por_seen_q, por_seen_d;
  cause_t     cause_q, cause_d;
  logic [7:0] prdata_d;
  logic       pready_d, pslverr_d;

  hold_if hif ();

  // brown-out requests count only while software has the detector enabled
  assign bod_ev = sync2_q[3] & ~prev_q[3] & bod_enable_q;

  // one-hot priority pick: brown-out, then clear pin, then watchdog, then pin change
  function automatic cause_t pick_cause(input logic c, w, p, b, h);
    if (b)            pick_cause = CAUSE_BROWNOUT; // R16
    else if (c && h)  pick_cause = CAUSE_CLR_WAKE;
    else if (c)       pick_cause = CAUSE_CLR_RUN;
    else if (w && h)  pick_cause = CAUSE_WDT_WAKE;
    else if (w)       pick_cause = CAUSE_WDT_RUN;
    else if (p)       pick_cause = CAUSE_PIN_WAKE;
    else              pick_cause = CAUSE_NONE;
  endfunction

  // word index from byte address; misaligned gives an out-of-range index
  function automatic logic [6:0] reg_index(input logic [7:0] a);
    reg_index = (a[1:0] == 2'b00) ? {1'b0, a[7:2]} : 7'h7F;
  endfunction

  cause_t     now_cause;
  logic [6:0] idx;
  logic       acc;
  logic       wr;
  assign now_cause = pick_cause(clr_ev, wdt_ev, pin_ev, bod_ev, halted); // R1
  assign idx       = reg_index(paddr);
  assign acc       = psel & penable & pready; // write lands where the master samples pready
  assign wr        = acc & pwrite;

  //////////////////////////////////////////////////////////////////////////////
  // next-state: software writes, then reset loads that override them
  always_comb begin
    status_d = status_q;
    pcl_d = pcl_q;
    ptr_d = ptr_q;
    tmr_d = tmr_q;
    port_a_latch_d = port_a_latch_q;
    port_b_latch_d = port_b_latch_q;
    wacc_d = wacc_q;
    dir_d = dir_q;
    opt_d = opt_q;
    optx_d = optx_q;
    gpr_d = gpr_q;
    bod_enable_d = bod_enable_q;
    por_seen_d = por_seen_q;
    cause_d = cause_q;
    hif.start = 1'b0;
    hif.short_sel = rc_osc_mode & por_seen_q; // R14
    // software writes only outside reset; flag bits 7,4,3 are read-only
    if (wr && !core_reset) begin
      case (idx)
        7'(`IDX_INDIRECT_DATA_PORT): begin
          if (ptr_q[4:0] >= `IDX_GPR_FIRST) gpr_d[ptr_q[4:0] - 5'd7] = pwdata[7:0];
        end
        7'(`IDX_TIMER_COUNT):        tmr_d = pwdata[7:0];
        7'(`IDX_PROGRAM_COUNTER_LOW): pcl_d = pwdata[7:0];
        7'(`IDX_STATUS_FLAGS): begin
          status_d = {status_q[7], pwdata[6:5], status_q[4:3], pwdata[2:0]};
        end
        7'(`IDX_INDIRECT_POINTER):   ptr_d = pwdata[7:0];
        7'(`IDX_PORT_A_LATCH):       port_a_latch_d = pwdata[3:0];
        7'(`IDX_PORT_B_LATCH):       port_b_latch_d = pwdata[7:0];
        7'(`IDX_WORKING_ACC):        wacc_d = pwdata[7:0];
        7'(`IDX_PIN_DIRECTION):      dir_d = pwdata[7:0];
        7'(`IDX_TIMER_OPTION):       opt_d = pwdata[5:0];
        7'(`IDX_OPTION_EXT):         optx_d = pwdata[5:0];
        7'(`IDX_CAUSE_CTRL):         bod_enable_d = pwdata[0];
        default: begin
          if (idx >= 7'(`IDX_GPR_FIRST) && idx <= 7'(`IDX_GPR_LAST)) begin
            gpr_d[idx[4:0] - 5'd7] = pwdata[7:0];
          end
        end
      endcase
    end
    if (watchdog_clear_instr && !core_reset) begin
      status_d[`ST_TIMEOUT_N]   = 1'b1; // R10
      status_d[`ST_POWERDOWN_N] = 1'b1;
    end
    // reset loads: every cause restarts hold and wakes never resume
    if (now_cause != CAUSE_NONE) begin
      hif.start = 1'b1; // R3 R15
      cause_d = now_cause;
      pcl_d = `RST_ALL_ONES; // R6
      dir_d = `RST_ALL_ONES; // R12
      opt_d = `RST_OPTION;
      ptr_d[7:5] = `RST_PTR_TOP; // R13
      por_seen_d = 1'b1;
      case (now_cause)
        CAUSE_CLR_RUN: begin
          status_d[6:5] = 2'b00; // R7 R8
        end
        CAUSE_CLR_WAKE: begin
          status_d[7:3] = 5'b10010;
        end
        CAUSE_WDT_RUN: begin
          status_d[6:3] = 4'b0001; // R9
        end
        CAUSE_WDT_WAKE: begin
          status_d[7:3] = 5'b10000;
        end
        CAUSE_PIN_WAKE: begin
          status_d[7:5] = 3'b000; // R11
        end
        CAUSE_BROWNOUT: begin
          status_d = 8'h00; // R11
          wacc_d = 8'h00;
          tmr_d = 8'h00;
          port_a_latch_d = 4'h0;
          port_b_latch_d = 8'h00;
          optx_d = 6'h00;
          bod_enable_d = 1'b0;
          ptr_d[4:0] = 5'h00; // unknown low pointer bits shown as zero
          for (int i = 0; i < 25; i++) gpr_d[i] = 8'h00; // R13
        end
        default: status_d = status_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait cycle, pready and data registered
  always_comb begin
    prdata_d  = 8'h00;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (psel && penable && !pready) begin
      pready_d = 1'b1;
      case (idx)
        7'(`IDX_INDIRECT_DATA_PORT): begin
          prdata_d = (ptr_q[4:0] >= `IDX_GPR_FIRST) ? gpr_q[ptr_q[4:0] - 5'd7] : 8'h00;
        end
        7'(`IDX_TIMER_COUNT):         prdata_d = tmr_q;
        7'(`IDX_PROGRAM_COUNTER_LOW): prdata_d = pcl_q;
        7'(`IDX_STATUS_FLAGS):        prdata_d = status_q;
        7'(`IDX_INDIRECT_POINTER):    prdata_d = ptr_q;
        7'(`IDX_PORT_A_LATCH):        prdata_d = {4'h0, port_a_latch_q};
        7'(`IDX_PORT_B_LATCH):        prdata_d = port_b_latch_q;
        7'(`IDX_WORKING_ACC):         prdata_d = wacc_q;
        7'(`IDX_PIN_DIRECTION):       prdata_d = dir_q;
        7'(`IDX_TIMER_OPTION):        prdata_d = {2'b00, opt_q};
        7'(`IDX_OPTION_EXT):          prdata_d = {2'b00, optx_q};
        7'(`IDX_CAUSE_CTRL):          prdata_d = {7'h00, bod_enable_q};
        7'(`IDX_HOLD_STATUS):         prdata_d = cause_q;
        default: begin
          if (idx >= 7'(`IDX_GPR_FIRST) && idx <= 7'(`IDX_GPR_LAST)) begin
            prdata_d = gpr_q[idx[4:0] - 5'd7];
          end else begin
            pslverr_d = 1'b1; // unmapped: error, no effect
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; power-on is the asynchronous reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_q <= `RST_STATUS_POR; // R4
      pcl_q <= `RST_ALL_ONES; // R6
      ptr_q <= {`RST_PTR_TOP, 5'h00}; // R13
      tmr_q <= 8'h00; // R2 unknown shown as zero
      port_a_latch_q <= 4'h0;
      port_b_latch_q <= 8'h00;
      wacc_q <= 8'h00;
      dir_q <= `RST_ALL_ONES; // R5 R12
      opt_q <= `RST_OPTION;
      optx_q <= `RST_OPTION;
      for (int i = 0; i < 25; i++) gpr_q[i] <= 8'h00;
      bod_enable_q <= 1'b0;
      por_seen_q <= 1'b0;
      cause_q <= CAUSE_POR;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      core_reset <= 1'b1;
      last_cause <= 8'h01;
    end else begin
      status_q <= status_d;
      pcl_q <= pcl_d;
      ptr_q <= ptr_d;
      tmr_q <= tmr_d;
      port_a_latch_q <= port_a_latch_d;
      port_b_latch_q <= port_b_latch_d;
      wacc_q <= wacc_d;
      dir_q <= dir_d;
      opt_q <= opt_d;
      optx_q <= optx_d;
      gpr_q <= gpr_d;
      bod_enable_q <= bod_enable_d;
      por_seen_q <= por_seen_d;
      cause_q <= cause_d;
      prdata <= {24'h0, prdata_d};
      pready <= pready_d;
      pslverr <= pslverr_d;
      core_reset <= hif.busy | hif.start; // R14 R17
      last_cause <= cause_d;
    end
  end

  startup_hold_timer #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC)
  ) u_hold (
    .clock (clock),
    .nrst  (nrst),
    .hif   (hif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks
  AST_PCL_ONES: assert property (@(posedge clock) disable iff (!nrst)
    now_cause != CAUSE_NONE |=> pcl_q == 8'hFF) // R6
    else $error("program counter low not all ones after reset");
  AST_CLR_RUN: assert property (@(posedge clock) disable iff (!nrst)
    now_cause == CAUSE_CLR_RUN |=> status_q[6:5] == 2'b00
      && status_q[4:3] == $past(status_q[4:3]) && status_q[7] == $past(status_q[7])) // R7
    else $error("clear reset status wrong");
  AST_WDT_RUN: assert property (@(posedge clock) disable iff (!nrst)
    now_cause == CAUSE_WDT_RUN |=> status_q[6:3] == 4'b0001) // R9
    else $error("watchdog reset status wrong");
  AST_PIN_WAKE: assert property (@(posedge clock) disable iff (!nrst)
    now_cause == CAUSE_PIN_WAKE |=> status_q[7:5] == 3'b000) // R11
    else $error("pin wake status wrong");
  AST_WDT_CLR: assert property (@(posedge clock) disable iff (!nrst)
    (watchdog_clear_instr && !core_reset && now_cause == CAUSE_NONE)
      |=> status_q[4:3] == 2'b11) // R10
    else $error("watchdog clear did not set flags");
  AST_DIR_OPT: assert property (@(posedge clock) disable iff (!nrst)
    now_cause != CAUSE_NONE |=> dir_q == 8'hFF && opt_q == 6'h3F && ptr_q[7:5] == 3'h7) // R12
    else $error("direction or option not reset");
  AST_HOLD_CORE: assert property (@(posedge clock) disable iff (!nrst)
    now_cause != CAUSE_NONE |=> core_reset [*2]) // R3
    else $error("core not held after wake");
  AST_BOD_WINS: assert property (@(posedge clock) disable iff (!nrst)
    (bod_ev && (clr_ev || wdt_ev)) |=> cause_q == CAUSE_BROWNOUT) // R16
    else $error("brown-out did not win");
endmodule

// [reset_source_model.sv]
// behavioural model of the reset sources: clear pin, watchdog, pin change, brown-out
module reset_source_model (
  // clock
  input  wire logic clock,
  // reset source lines
  output logic      master_clear_pin_n,
  output logic      watchdog_timeout,
  output logic      pin_change,
  output logic      brownout
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels: clear pin released high, the others quiet
  initial begin
    master_clear_pin_n = 1'b1;
    watchdog_timeout   = 1'b0;
    pin_change         = 1'b0;
    brownout           = 1'b0;
  end

  // raise the chosen sources together for len cycles; a long len models a slow source
  task automatic fire(input logic [3:0] m, input int len);
    @(posedge clock);
    master_clear_pin_n <= ~m[0];
    watchdog_timeout   <= m[1];
    pin_change         <= m[2];
    brownout           <= m[3];
    repeat (len) @(posedge clock);
    master_clear_pin_n <= 1'b1;
    watchdog_timeout   <= 1'b0;
    pin_change         <= 1'b0;
    brownout           <= 1'b0;
  endtask
endmodule

// [reset_source_state_control_tb.sv]
// self-checking bench of the reset controller: causes, status patterns, hold times, apb
`include "reset_ctrl_regs.svh"
module reset_source_state_control_tb
  import reset_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned LONG  = 40;
  localparam int unsigned SHORT = 10;
  localparam logic [7:0]  A_PC  = 8'(`IDX_PROGRAM_COUNTER_LOW * 4);
  localparam logic [7:0]  A_ST  = 8'(`IDX_STATUS_FLAGS * 4);
  localparam logic [7:0]  A_PTR = 8'(`IDX_INDIRECT_POINTER * 4);
  localparam logic [7:0]  A_GPR = 8'(`IDX_GPR_FIRST * 4);
  localparam logic [7:0]  A_ACC = 8'(`IDX_WORKING_ACC * 4);
  localparam logic [7:0]  A_DIR = 8'(`IDX_PIN_DIRECTION * 4);
  localparam logic [7:0]  A_OPT = 8'(`IDX_TIMER_OPTION * 4);
  localparam logic [7:0]  A_EXT = 8'(`IDX_OPTION_EXT * 4);
  localparam logic [7:0]  A_CTL = 8'(`IDX_CAUSE_CTRL * 4);

  logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, last_cause;
  logic [31:0] pwdata, prdata, rd;
  logic        master_clear_pin_n, watchdog_timeout, pin_change, brownout;
  logic        halted, watchdog_clear_instr, rc_osc_mode, core_reset, err;
  int          failures, total_checks, cycles, run_cnt, last_hold;

  reset_source_state_control #(.LONG_CYC(LONG), .SHORT_CYC(SHORT)) dut_u (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clear_pin_n(master_clear_pin_n), .watchdog_timeout(watchdog_timeout),
    .pin_change(pin_change), .brownout(brownout), .halted(halted),
    .watchdog_clear_instr(watchdog_clear_instr), .rc_osc_mode(rc_osc_mode),
    .core_reset(core_reset), .last_cause(last_cause));

  reset_source_model src_u (
    .clock(clock), .master_clear_pin_n(master_clear_pin_n),
    .watchdog_timeout(watchdog_timeout), .pin_change(pin_change), .brownout(brownout));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // length of the latest hold, measured independently of the design's own counter
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (core_reset === 1'b1) begin
      run_cnt <= run_cnt + 1;
    end else begin
      if (run_cnt != 0) last_hold <= run_cnt;
      run_cnt <= 0;
    end
    if (cycles == 20000) begin
      failures = failures + 1;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rd, exp);
  endtask

  task automatic wait_low();
    int n;
    for (n = 0; n < 300 && core_reset !== 1'b0; n++) @(posedge clock);
    @(posedge clock);
  endtask

  // fire sources, then wait until the hold ends and judge its length
  task automatic cause(input logic [3:0] m, input logic h, input int hold);
    int n;
    halted <= h;
    src_u.fire(m, 4);
    for (n = 0; n < 30 && core_reset !== 1'b1; n++) @(posedge clock);
    halted <= 1'b0;
    wait_low();
    chk("hold", last_hold >= hold && last_hold <= hold + 3, 1'b1);
  endtask

  task automatic t_power_on();
    apb(1'b1, A_GPR, 32'h0000_005A); // ignored while the core is held
    wait_low();
    chk("por hold", last_hold >= LONG + 8 && last_hold <= LONG + 11, 1'b1);
    chk("por cause", last_cause, CAUSE_POR);
    rchk("por status", A_ST, `RST_STATUS_POR);
    rchk("por pc", A_PC, `RST_ALL_ONES);
    rchk("por ptr", A_PTR, 32'h0000_00E0);
    rchk("por gpr", A_GPR, 32'h0000_0000);
    rchk("por dir", A_DIR, `RST_ALL_ONES);
    rchk("por opt", A_OPT, `RST_OPTION);
    rchk("por ext", A_EXT, `RST_OPTION);
    $display("test power_on done");
  endtask

  task automatic t_clear_run();
    apb(1'b1, A_ST, 32'h0000_0067);
    apb(1'b1, A_GPR, 32'h0000_005A);
    apb(1'b1, A_PTR, 32'h0000_001F);
    apb(1'b1, A_PC, 32'h0000_0012);
    apb(1'b1, A_EXT, 32'h0000_0015);
    apb(1'b1, A_ACC, 32'h0000_0033);
    apb(1'b1, A_DIR, 32'h0000_0000);
    apb(1'b1, A_OPT, 32'h0000_0000);
    cause(4'b0001, 1'b0, LONG);
    chk("clr cause", last_cause, CAUSE_CLR_RUN);
    rchk("clr status", A_ST, 32'h0000_009F);
    rchk("clr pc", A_PC, `RST_ALL_ONES);
    rchk("clr gpr", A_GPR, 32'h0000_005A);
    rchk("clr ptr", A_PTR, 32'h0000_00FF);
    rchk("clr ext", A_EXT, 32'h0000_0015);
    rchk("clr acc", A_ACC, 32'h0000_0033);
    rchk("clr dir", A_DIR, `RST_ALL_ONES);
    rchk("clr opt", A_OPT, `RST_OPTION);
    $display("test clear_run done");
  endtask

  task automatic t_watchdog_run();
    apb(1'b1, A_ST, 32'h0000_0067);
    cause(4'b0010, 1'b0, LONG);
    chk("wd cause", last_cause, CAUSE_WDT_RUN);
    rchk("wd status", A_ST, 32'h0000_008F);
    cause(4'b0001, 1'b0, LONG);
    rchk("wd then clr", A_ST, 32'h0000_008F);
    @(posedge clock);
    watchdog_clear_instr <= 1'b1;
    @(posedge clock);
    watchdog_clear_instr <= 1'b0;
    rchk("clear instr", A_ST, 32'h0000_009F);
    $display("test watchdog_run done");
  endtask

  task automatic t_wake();
    logic [3:0] m [3] = '{4'b0001, 4'b0010, 4'b0100};
    logic [7:0] s [3] = '{8'h97, 8'h87, 8'h07};
    cause_t     c [3] = '{CAUSE_CLR_WAKE, CAUSE_WDT_WAKE, CAUSE_PIN_WAKE};
    rc_osc_mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      cause(m[i], 1'b1, SHORT);
      chk("wake cause", last_cause, c[i]);
      rchk("wake status", A_ST, {24'h0, s[i]});
      rchk("wake pc", A_PC, `RST_ALL_ONES);
      rchk("wake gpr", A_GPR, 32'h0000_005A);
    end
    src_u.fire(4'b0100, 4);
    repeat (8) @(posedge clock);
    chk("pin while running", core_reset, 1'b0);
    rc_osc_mode <= 1'b0;
    $display("test wake done");
  endtask

  task automatic t_priority();
    apb(1'b1, A_ST, 32'h0000_0067);
    cause(4'b0011, 1'b0, LONG);
    chk("prio cause", last_cause, CAUSE_CLR_RUN);
    rchk("prio status", A_ST, 32'h0000_0007);
    $display("test priority done");
  endtask

  task automatic t_brownout();
    apb(1'b1, A_CTL, 32'h0000_0001);
    cause(4'b1001, 1'b0, LONG);
    chk("bo cause", last_cause, CAUSE_BROWNOUT);
    rchk("bo status", A_ST, 32'h0000_0000);
    rchk("bo gpr", A_GPR, 32'h0000_0000);
    rchk("bo ptr", A_PTR, 32'h0000_00E0);
    rchk("bo dir", A_DIR, `RST_ALL_ONES);
    $display("test brownout done");
  endtask

  task automatic t_bus_errors();
    apb(1'b0, 8'h98, 32'h0000_0000);
    chk("unmapped err", err, 1'b1);
    apb(1'b0, 8'h0D, 32'h0000_0000);
    chk("misaligned err", err, 1'b1);
    apb(1'b0, A_ST, 32'h0000_0000);
    chk("mapped err", err, 1'b0);
    $display("test bus_errors done");
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // reset, then the scenarios in order; each builds on the status left by the last
  initial begin
    failures = 0;
    total_checks = 0;
    cycles = 0;
    run_cnt = 0;
    last_hold = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    halted = 1'b0;
    watchdog_clear_instr = 1'b0;
    rc_osc_mode = 1'b0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    t_power_on();
    t_clear_run();
    t_watchdog_run();
    t_wake();
    t_priority();
    t_brownout();
    t_bus_errors();
    summarize();
  end
endmodule
